// File: include/gdm_pkg.sv
// gdm_pkg: constants shared by the generic slave dma block
// assumes a 32-bit apb register bus and one indexed endpoint
package gdm_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_EP_TYPE = 12'h208;
  localparam logic [11:0] ADDR_DMA_CMD = 12'h230;
  localparam logic [11:0] ADDR_BYTE_COUNT = 12'h234;
  localparam logic [11:0] ADDR_DMA_CONFIG = 12'h238;
  localparam logic [11:0] ADDR_DMA_STATUS = 12'h23c;
  localparam logic [11:0] ADDR_DMA_MASK = 12'h240;

  // ----------------------------------------------------------------
  // endpoint type fields
  // ----------------------------------------------------------------
  localparam int EP_KIND_LSB = 0;
  localparam int EP_DBL_BIT = 2;
  localparam int EP_ENABLE_BIT = 3;
  localparam int EP_ZLS_BIT = 4;
  localparam int EP_USED_BITS = 5;
  localparam logic [1:0] KIND_ISO = 2'h1;
  localparam logic [1:0] KIND_BULK = 2'h2;
  localparam logic [1:0] KIND_INTR = 2'h3;

  // ----------------------------------------------------------------
  // dma configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_WIDTH_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_BYPASS_BIT = 3;
  localparam int CFG_REQ_POL_BIT = 4;
  localparam int CFG_ACK_POL_BIT = 5;
  localparam int CFG_PERMIT_BIT = 6;
  localparam int CFG_CLKON_BIT = 7;
  localparam int CFG_BITS = 8;
  localparam logic [1:0] MODE_SPLIT = 2'h0;
  localparam logic [1:0] MODE_WR_ONLY = 2'h1;
  localparam logic [1:0] MODE_RD_ONLY = 2'h2;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  localparam int ST_COUNT_DONE = 0;
  localparam int ST_SHORT_END = 1;
  localparam int ST_STOP_DONE = 2;
  localparam int ST_BITS = 3;

  // ----------------------------------------------------------------
  // commands and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESET_VALUE = 8'hff;
  localparam logic [7:0] CMD_READ_VALUE = 8'hff;
  localparam logic [7:0] CMD_DMA_IN = 8'h00;
  localparam logic [7:0] CMD_DMA_OUT = 8'h01;
  localparam logic [7:0] CMD_VALIDATE = 8'h0e;
  localparam logic [7:0] CMD_CLEAR_BUF = 8'h0f;
  localparam logic [7:0] CMD_DMA_RESET = 8'h11;
  localparam logic [7:0] CMD_DMA_STOP = 8'h13;
  localparam logic [31:0] BYTES_16 = 32'h2;
  localparam logic [31:0] BYTES_32 = 32'h4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IN,
    ST_OUT
  } gdm_state_type;

endpackage

// File: rtl/gdm_dma_slave.sv
// gdm_dma_slave: endpoint type register and generic slave dma command path
// assumes apb master on clk, external pins already synchronous to clk
//
// Contract
// - with suppression bit clear, finished dma in transfer queues a null packet; code queues it only when the count reaches zero, not on stop
// - endpoint enable bit switches the indexed endpoint buffer on or off
// - disabling then re-enabling an endpoint resets its data toggle
// - double buffer bit selects double or single buffering
// - kind field: 01 isochronous, 10 bulk, 11 interrupt, 00 unused
// - shared read and write strobes steered to dma or register access
// - active count loads only when the most significant byte is written
// - counter decrements per byte moved; zero sets count done flag
// - transfer starts as soon as a transfer command is written
// - short packet, dma reset or stop command ends a running transfer
// - short packet end and count done flags are separately maskable
// - data bus floats until an out command runs; other outputs always driven
// - command register write-only, reads ff, resets to all ones
// - command 00h moves dma bus data into the endpoint buffer
// - command 01h moves endpoint buffer data onto the dma bus
// - command 0eh validates endpoint buffer; 02h to 0dh reserved
// - width selects 16 or 32 bit bus; mode picks active strobes
// - separate polarity bits for request output and ack input
// - command 13h stops transfer, flushes in data, sets completion flag
// - command 11h returns the dma core to its reset state; code keeps config and mask
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module gdm_dma_slave
  import gdm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic pio_rd_n,
  output logic pio_wr_n,
  input wire logic dma_ack_line,
  output logic dma_request_line,
  input wire logic [31:0] dma_data_in,
  output logic [31:0] dma_data_out,
  output logic dma_data_oe,
  output logic ep_buffer_enable,
  output logic ep_double_buffer,
  output logic ep_is_iso,
  output logic ep_is_bulk,
  output logic ep_is_intr,
  output logic toggle_reset,
  input wire logic usb_in_token,
  output logic zero_length_packet_req,
  input wire logic out_short_packet,
  input wire logic buf_wr_ready,
  output logic buf_wr_valid,
  output logic [31:0] buf_wr_data,
  output logic [2:0] buf_wr_bytes,
  input wire logic buf_rd_valid,
  input wire logic [31:0] buf_rd_data,
  output logic buf_rd_take,
  output logic buf_validate,
  output logic buf_clear,
  output logic buf_flush,
  output logic dma_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] dec_count(input logic [31:0] cnt, input logic [31:0] step);
    dec_count = (cnt > step) ? cnt - step : '0;
  endfunction

  function automatic logic pick_strobe(input logic [1:0] mode, input logic to_dev,
                                       input logic rd_low, input logic wr_low);
    unique case (mode)
      MODE_SPLIT: pick_strobe = to_dev ? wr_low : rd_low;
      MODE_WR_ONLY: pick_strobe = wr_low;
      MODE_RD_ONLY: pick_strobe = rd_low;
      default: pick_strobe = rd_low | wr_low;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gdm_state_type state_q, state_d;
  logic [EP_USED_BITS-1:0] ep_type_q;
  logic [23:0] count_low_q;
  logic [31:0] count_q, count_d;
  logic [CFG_BITS-1:0] cfg_q;
  logic [ST_BITS-1:0] flags_q, flags_d;
  logic [ST_BITS-1:0] mask_q;
  logic strobe_low_q;
  logic zlp_q;
  logic [31:0] data_out_q;
  logic wr_valid_q;
  logic [31:0] wr_data_q;
  logic [2:0] wr_bytes_q;
  logic validate_q, clear_q, flush_q, toggle_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_go = psel & penable;
  wire apb_wr = apb_go & pwrite;
  wire hit_ep = (paddr == ADDR_EP_TYPE);
  wire hit_cmd = (paddr == ADDR_DMA_CMD);
  wire hit_cnt = (paddr == ADDR_BYTE_COUNT);
  wire hit_cfg = (paddr == ADDR_DMA_CONFIG);
  wire hit_st = (paddr == ADDR_DMA_STATUS);
  wire hit_mask = (paddr == ADDR_DMA_MASK);
  wire hit_any = hit_ep | hit_cmd | hit_cnt | hit_cfg | hit_st | hit_mask;
  wire wr_ep = apb_wr & hit_ep;
  wire wr_cmd = apb_wr & hit_cmd & pstrb[0];
  wire wr_cnt_msb = apb_wr & hit_cnt & pstrb[3];
  wire wr_cfg = apb_wr & hit_cfg & pstrb[0];
  wire wr_st = apb_wr & hit_st & pstrb[0];
  wire wr_mask = apb_wr & hit_mask & pstrb[0];

  wire [7:0] cmd_code = pwdata[7:0];
  wire cmd_in = wr_cmd & (cmd_code == CMD_DMA_IN);
  wire cmd_out = wr_cmd & (cmd_code == CMD_DMA_OUT);
  wire cmd_valid = wr_cmd & (cmd_code == CMD_VALIDATE);
  wire cmd_clear = wr_cmd & (cmd_code == CMD_CLEAR_BUF);
  wire cmd_rst = wr_cmd & (cmd_code == CMD_DMA_RESET);
  wire cmd_stop = wr_cmd & (cmd_code == CMD_DMA_STOP);
  wire cmd_known = cmd_in | cmd_out | cmd_valid | cmd_clear | cmd_rst | cmd_stop;

  // zero wait states; anything outside the map answers with pslverr
  assign pready = 1'b1;
  assign pslverr = apb_go & ~hit_any;

  // reserved endpoint bits read zero
  wire [31:0] rd_ep = {{(32-EP_USED_BITS){1'b0}}, ep_type_q};
  // write-only command register always reads ff in the low byte, zeros above
  wire [31:0] rd_cmd = {24'h0, CMD_READ_VALUE};
  assign prdata = hit_ep ? rd_ep :
                  hit_cmd ? rd_cmd :
                  hit_cnt ? count_q :
                  hit_cfg ? {{(32-CFG_BITS){1'b0}}, cfg_q} :
                  hit_st ? {{(32-ST_BITS){1'b0}}, flags_q} :
                  hit_mask ? {{(32-ST_BITS){1'b0}}, mask_q} : 32'h0;

  // ----------------------------------------------------------------
  // endpoint type fields
  // ----------------------------------------------------------------
  wire [1:0] ep_kind = ep_type_q[EP_KIND_LSB +: 2];
  wire zero_length_suppress = ep_type_q[EP_ZLS_BIT];
  assign ep_buffer_enable = ep_type_q[EP_ENABLE_BIT];
  assign ep_double_buffer = ep_type_q[EP_DBL_BIT];
  assign ep_is_iso = (ep_kind == KIND_ISO);
  assign ep_is_bulk = (ep_kind == KIND_BULK);
  assign ep_is_intr = (ep_kind == KIND_INTR);
  assign toggle_reset = toggle_q;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire width_32 = cfg_q[CFG_WIDTH_BIT];
  wire [1:0] strobe_mode = cfg_q[CFG_MODE_LSB +: 2];
  wire counter_bypass = cfg_q[CFG_BYPASS_BIT];
  wire request_polarity = cfg_q[CFG_REQ_POL_BIT];
  wire ack_polarity = cfg_q[CFG_ACK_POL_BIT];
  wire transfer_permit = cfg_q[CFG_PERMIT_BIT];
  wire dma_clock_gate_on = cfg_q[CFG_CLKON_BIT];

  // ----------------------------------------------------------------
  // dma handshake and strobe steering
  // ----------------------------------------------------------------
  wire run_in = (state_q == ST_IN);
  wire run_out = (state_q == ST_OUT);
  wire running = run_in | run_out;
  wire [31:0] step = width_32 ? BYTES_32 : BYTES_16;
  // count mode ends at zero; bypass leaves only stop, dma reset or short packet
  wire count_hit = running & ~counter_bypass & (count_q == 32'h0);
  wire side_ready = run_in ? buf_wr_ready : buf_rd_valid;
  // no request without clock gate and permit, so a half-set core stays quiet
  wire req_int = running & ~count_hit & side_ready
                 & transfer_permit & dma_clock_gate_on;
  assign dma_request_line = request_polarity ? req_int : ~req_int;
  wire ack_active = ack_polarity ? dma_ack_line : ~dma_ack_line;

  // shared strobes go to the dma engine while running, else to pio
  assign pio_rd_n = running ? 1'b1 : rd_n;
  assign pio_wr_n = running ? 1'b1 : wr_n;
  wire strobe_low = running & pick_strobe(strobe_mode, run_in, ~rd_n, ~wr_n);
  wire beat = req_int & ack_active & strobe_low & ~strobe_low_q;
  assign buf_rd_take = beat & run_out;

  // bus floats unless an out command is executing
  assign dma_data_oe = run_out;
  assign dma_data_out = data_out_q;
  assign buf_wr_valid = wr_valid_q;
  assign buf_wr_data = wr_data_q;
  assign buf_wr_bytes = wr_bytes_q;
  assign buf_validate = validate_q;
  assign buf_clear = clear_q;
  assign buf_flush = flush_q;
  assign zero_length_packet_req = zlp_q;
  assign dma_irq = |(flags_q & mask_q);

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  wire short_end = run_out & out_short_packet;
  wire in_done = run_in & count_hit;
  wire [31:0] new_count = {pwdata[31:24],
                           pstrb[2] ? pwdata[23:16] : count_low_q[23:16],
                           pstrb[1] ? pwdata[15:8] : count_low_q[15:8],
                           pstrb[0] ? pwdata[7:0] : count_low_q[7:0]};

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    flags_d = flags_q;
    if (beat && !counter_bypass) begin
      count_d = dec_count(count_q, step);
    end
    if (wr_cnt_msb) begin
      count_d = new_count;
    end
    if (count_hit || short_end) begin
      state_d = ST_IDLE;
    end
    if (wr_st) begin
      flags_d = flags_q & ~pwdata[ST_BITS-1:0];
    end
    // hardware sets win over status register clears; a dma reset command clears all flags
    if (count_hit) begin
      flags_d[ST_COUNT_DONE] = 1'b1;
    end
    if (short_end) begin
      flags_d[ST_SHORT_END] = 1'b1;
    end
    if (cmd_in) begin
      state_d = ST_IN;
    end
    if (cmd_out) begin
      state_d = ST_OUT;
    end
    if (cmd_stop) begin
      state_d = ST_IDLE;
      flags_d[ST_STOP_DONE] = 1'b1;
    end
    if (cmd_rst) begin
      state_d = ST_IDLE;
      count_d = '0;
      flags_d = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      count_q <= '0;
      flags_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ep_type_q <= '0;
      toggle_q <= 1'b0;
    end else begin
      // re-enable after disable clears the toggle of this endpoint
      toggle_q <= wr_ep & pstrb[0] & pwdata[EP_ENABLE_BIT] & ~ep_type_q[EP_ENABLE_BIT];
      if (wr_ep && pstrb[0]) begin
        ep_type_q <= pwdata[EP_USED_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_low_q <= '0;
      cfg_q <= '0;
      mask_q <= '0;
    end else begin
      if (cmd_rst) begin
        count_low_q <= '0;
      end else begin
        if (apb_wr && hit_cnt) begin
          count_low_q <= new_count[23:0];
        end
      end
      if (wr_cfg) begin
        cfg_q <= pwdata[CFG_BITS-1:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[ST_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strobe_low_q <= 1'b0;
      data_out_q <= '0;
      wr_valid_q <= 1'b0;
      wr_data_q <= '0;
      wr_bytes_q <= '0;
    end else begin
      strobe_low_q <= strobe_low;
      data_out_q <= run_out ? buf_rd_data : data_out_q;
      wr_valid_q <= beat & run_in;
      if (beat && run_in) begin
        wr_data_q <= dma_data_in;
        wr_bytes_q <= step[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      validate_q <= 1'b0;
      clear_q <= 1'b0;
      flush_q <= 1'b0;
      zlp_q <= 1'b0;
    end else begin
      validate_q <= cmd_valid;
      clear_q <= cmd_clear;
      // staged in data is committed to the endpoint on stop
      flush_q <= cmd_stop & run_in;
      // the null packet request holds until the next in token or a dma reset command clears it
      if (in_done && !zero_length_suppress) begin
        zlp_q <= 1'b1;
      end else if (usb_in_token || cmd_rst) begin
        zlp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_cmd_reads_ones: assert property (@(posedge clk) disable iff (srst)
    (apb_go && !pwrite && hit_cmd) |-> (prdata[7:0] == CMD_READ_VALUE))
    else $error("command register read not ff");

  chk_low_bytes_hold: assert property (@(posedge clk) disable iff (srst)
    (apb_wr && hit_cnt && !pstrb[3] && !running && !cmd_rst) |=> $stable(count_q))
    else $error("low count byte changed active count");

  chk_zero_sets_done: assert property (@(posedge clk) disable iff (srst)
    (count_hit && !cmd_rst && !cmd_in && !cmd_out) |=> (flags_q[ST_COUNT_DONE] && !running))
    else $error("count reached zero without done flag");

  chk_bus_floats_idle: assert property (@(posedge clk) disable iff (srst)
    $rose(dma_data_oe) |-> $past(cmd_out))
    else $error("data bus driven without out command");

  chk_reserved_cmd_idle: assert property (@(posedge clk) disable iff (srst)
    (wr_cmd && !cmd_known && !count_hit && !short_end && !beat && !wr_st)
      |=> ($stable(state_q) && $stable(flags_q) && !buf_validate && !buf_flush))
    else $error("reserved command had an effect");

  chk_toggle_on_reenable: assert property (@(posedge clk) disable iff (srst)
    toggle_reset |-> (ep_buffer_enable && !$past(ep_buffer_enable)))
    else $error("toggle reset without disable then enable");

  chk_stop_ends_run: assert property (@(posedge clk) disable iff (srst)
    (cmd_stop && !cmd_in && !cmd_out) |=> (!running ##0 flags_q[ST_STOP_DONE]))
    else $error("stop command did not end transfer");

  chk_ep_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    (apb_go && hit_ep) |-> (prdata[31:EP_USED_BITS] == '0))
    else $error("reserved endpoint bits not zero");

  chk_request_polarity: assert property (@(posedge clk) disable iff (srst)
    (!running) |-> (dma_request_line == !request_polarity))
    else $error("idle request line at wrong level");

  chk_null_packet: assert property (@(posedge clk) disable iff (srst)
    $rose(zero_length_packet_req) |-> $past(!zero_length_suppress && in_done))
    else $error("null packet queued with suppression set");

  chk_start_on_cmd: assert property (@(posedge clk) disable iff (srst)
    (cmd_out && !cmd_rst) |=> run_out)
    else $error("out command did not start transfer");

  chk_short_end: assert property (@(posedge clk) disable iff (srst)
    (short_end && !wr_cmd) |=> (!running && flags_q[ST_SHORT_END]))
    else $error("short packet did not end transfer");

endmodule // gdm_dma_slave

`default_nettype wire

// File: verification/gdm_dma_partner.sv
// gdm_dma_partner: external dma controller driving the shared strobes
// assumes active-high request and ack, split strobe mode
`timescale 1ns/1ns
`default_nettype none

module gdm_dma_partner (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic dir,
  input wire logic dma_request_line,
  output logic rd_n,
  output logic wr_n,
  output logic dma_ack_line,
  output logic [31:0] dma_data_in
);
  // ----------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------
  logic low_q;
  logic [31:0] pat_q;
  always_ff @(posedge clk) begin
    if (srst || !go) begin
      low_q <= 1'b0;
      dma_ack_line <= 1'b0;
    end else begin
      dma_ack_line <= dma_request_line;
      // strobe returns high between beats, so each low counts once
      low_q <= dma_request_line && !low_q;
    end
    pat_q <= srst ? 32'h0 : pat_q + 32'h01010101;
  end
  assign wr_n = !(low_q && !dir);
  assign rd_n = !(low_q && dir);
  // bus not acknowledged carries the inverse pattern, never a stale value
  assign dma_data_in = dma_ack_line ? pat_q : ~pat_q;
endmodule // gdm_dma_partner

`default_nettype wire

// File: verification/gdm_dma_slave_bench.sv
// gdm_dma_slave_bench: self-checking bench for the generic slave dma block
// assumes a 250 MHz clk and the partner model on the dma pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %0t got %h want %h", $time, g, e); end end

module gdm_dma_slave_bench;
  import gdm_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, dir = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat, dma_data_in, dma_data_out, buf_wr_data;
  logic [3:0] pstrb = 0;
  logic usb_in_token = 0, out_short_packet = 0, serr, pready, pslverr, rd_n, wr_n, ack;
  logic req, oe, ep_en, ep_dbl, k_iso, k_bulk, k_intr, tog, zlp, wv, take, val, clr, fl, irq;
  logic prd, pwr;
  int n_clr = 0, n_pio = 0;
  logic [2:0] wbytes;
  int compares = 0, miscompares = 0, n_wr = 0, n_tog = 0, n_val = 0, n_fl = 0, cyc = 0, m;

  always #2 clk = ~clk;

  gdm_dma_partner u_far (.clk(clk), .srst(srst), .go(go), .dir(dir),
    .dma_request_line(req), .rd_n(rd_n), .wr_n(wr_n), .dma_ack_line(ack),
    .dma_data_in(dma_data_in));

  gdm_dma_slave dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_n(rd_n), .wr_n(wr_n), .pio_rd_n(prd),
    .pio_wr_n(pwr), .dma_ack_line(ack), .dma_request_line(req), .dma_data_in(dma_data_in),
    .dma_data_out(dma_data_out), .dma_data_oe(oe), .ep_buffer_enable(ep_en),
    .ep_double_buffer(ep_dbl), .ep_is_iso(k_iso), .ep_is_bulk(k_bulk), .ep_is_intr(k_intr),
    .toggle_reset(tog), .usb_in_token(usb_in_token), .zero_length_packet_req(zlp),
    .out_short_packet(out_short_packet), .buf_wr_ready(1'b1), .buf_wr_valid(wv),
    .buf_wr_data(buf_wr_data), .buf_wr_bytes(wbytes), .buf_rd_valid(1'b1),
    .buf_rd_data(32'h5a5a_a5a5), .buf_rd_take(take), .buf_validate(val),
    .buf_clear(clr), .buf_flush(fl), .dma_irq(irq));

  // ----------------------------------------------------------------
  // pulse counters and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    n_wr += (wv === 1'b1);
    n_tog += (tog === 1'b1);
    n_val += (val === 1'b1);
    n_fl += (fl === 1'b1);
    n_clr += (clr === 1'b1);
    // strobes only move while a transfer runs, so pio side must stay high
    n_pio += (!srst && (prd !== 1'b1 || pwr !== 1'b1));
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge clk);
  endtask

  task set_count(input logic [31:0] v);
    apb(1, ADDR_BYTE_COUNT, v, 4'h7);
    apb(1, ADDR_BYTE_COUNT, v, 4'h8);
  endtask

  task wait_st(input int b);
    int n;
    n = 0;
    rdat = 0;
    while (rdat[b] !== 1'b1 && n < 40) begin
      apb(0, ADDR_DMA_STATUS, 0, 0);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    apb(0, ADDR_DMA_CMD, 0, 0);
    `CHK(rdat[7:0], CMD_RESET_VALUE)
    apb(1, ADDR_DMA_CMD, 32'h0000_0005, 4'h1);
    apb(0, ADDR_DMA_CMD, 0, 0);
    `CHK(rdat[7:0], CMD_READ_VALUE)
    apb(0, 12'h300, 0, 0);
    `CHK(serr, 1'b1)
    apb(1, ADDR_EP_TYPE, 32'hffff_ffff, 4'hf);
    apb(0, ADDR_EP_TYPE, 0, 0);
    `CHK(rdat, 32'h0000_001f)
    `CHK({ep_en, ep_dbl}, 2'b11)
    for (int k = 0; k < 4; k++) begin
      apb(1, ADDR_EP_TYPE, k, 4'h1);
      `CHK({k_intr, k_bulk, k_iso}, (k == 0) ? 3'b000 : 3'b001 << (k - 1))
      `CHK({ep_en, ep_dbl}, 2'b00)
    end
    m = n_tog;
    apb(1, ADDR_EP_TYPE, 32'h0000_000a, 4'h1);
    apb(1, ADDR_EP_TYPE, 32'h0000_000a, 4'h1);
    `CHK(n_tog - m, 1)
  endtask

  task t_in;
    apb(1, ADDR_BYTE_COUNT, 32'h0000_0010, 4'h7);
    apb(0, ADDR_BYTE_COUNT, 0, 0);
    `CHK(rdat, 32'h0)
    apb(1, ADDR_BYTE_COUNT, 32'h0, 4'h8);
    apb(0, ADDR_BYTE_COUNT, 0, 0);
    `CHK(rdat, 32'h0000_0010)
    apb(1, ADDR_DMA_CONFIG, 32'h0000_00f1, 4'h1);
    apb(1, ADDR_DMA_MASK, 32'h1, 4'h1);
    set_count(32'h8);
    m = n_wr;
    @(posedge clk);
    go <= 1;
    apb(1, ADDR_DMA_CMD, CMD_DMA_IN, 4'h1);
    wait_st(ST_COUNT_DONE);
    `CHK(rdat[ST_COUNT_DONE], 1'b1)
    `CHK(n_wr - m, 2)
    `CHK(wbytes, 3'h4)
    `CHK(n_pio, 0)
    `CHK({zlp, irq, oe}, 3'b110)
    @(posedge clk);
    go <= 0;
    apb(0, ADDR_BYTE_COUNT, 0, 0);
    `CHK(rdat, 32'h0)
    @(posedge clk);
    usb_in_token <= 1;
    @(posedge clk);
    usb_in_token <= 0;
    apb(1, ADDR_DMA_STATUS, 32'h7, 4'h1);
    `CHK({zlp, irq}, 2'b00)
  endtask

  task t_out;
    set_count(32'h8);
    @(posedge clk);
    dir <= 1;
    apb(1, ADDR_DMA_CMD, CMD_DMA_OUT, 4'h1);
    `CHK(oe, 1'b1)
    @(posedge clk);
    out_short_packet <= 1;
    @(posedge clk);
    out_short_packet <= 0;
    wait_st(ST_SHORT_END);
    `CHK({rdat[ST_SHORT_END], oe, irq}, 3'b100)
    `CHK(dma_data_out, 32'h5a5a_a5a5)
    apb(1, ADDR_DMA_STATUS, 32'h7, 4'h1);
  endtask

  task t_cmds;
    set_count(32'h8);
    apb(1, ADDR_DMA_CMD, CMD_DMA_IN, 4'h1);
    m = n_fl;
    apb(1, ADDR_DMA_CMD, CMD_DMA_STOP, 4'h1);
    wait_st(ST_STOP_DONE);
    `CHK(rdat[ST_STOP_DONE], 1'b1)
    `CHK(n_fl - m, 1)
    m = n_val;
    apb(1, ADDR_DMA_CMD, CMD_VALIDATE, 4'h1);
    apb(1, ADDR_DMA_CMD, CMD_CLEAR_BUF, 4'h1);
    apb(0, ADDR_DMA_CMD, 0, 0);
    `CHK(n_val - m, 1)
    `CHK(n_clr, 1)
    set_count(32'h20);
    apb(1, ADDR_DMA_CMD, 32'h0000_0005, 4'h1);
    apb(0, ADDR_BYTE_COUNT, 0, 0);
    `CHK({rdat, oe}, {32'h20, 1'b0})
    apb(1, ADDR_DMA_CMD, CMD_DMA_OUT, 4'h1);
    apb(1, ADDR_DMA_CMD, CMD_DMA_RESET, 4'h1);
    apb(0, ADDR_BYTE_COUNT, 0, 0);
    `CHK({rdat, oe}, 33'h0)
  endtask

  task report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    srst <= 0;
    t_regs;
    t_in;
    t_out;
    t_cmds;
    report_and_stop;
  end
endmodule // gdm_dma_slave_bench

`default_nettype wire
